// [rtl/brs_defs.vh]
// Constants for the brown-out reset sequencer: offsets, fields, resets, times.
`ifndef BRS_DEFS_VH
`define BRS_DEFS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define BRS_CLK_MHZ       125
`define BRS_TICK_NS       1000
`define BRS_POWERUP_TIMER_US       72000
`define BRS_FILT_US       100
`define BRS_OST_PERIODS   1024

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define BRS_A_CONFIG      8'h00
`define BRS_A_POWER_CONTROL_STATUS        8'h04
`define BRS_A_STATUS      8'h08
`define BRS_A_IRQSTAT     8'h0c
`define BRS_A_IRQMASK     8'h10
`define BRS_A_DEFAULTS    8'h14
`define BRS_A_PERIOD      8'h18
`define BRS_A_SEQ         8'h1c

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define BRS_POWER_CONTROL_STATUS_BOR      0
`define BRS_POWER_CONTROL_STATUS_POR      1
`define BRS_POWER_CONTROL_STATUS_OSCF     3
`define BRS_EV_BOR        0
`define BRS_EV_POR        1
`define BRS_EV_EXTERNAL_RESET_PIN_N       2
`define BRS_EV_WDT        3
`define BRS_EV_WAKE       4
`define BRS_CONFIG_RST    7'h14
`define BRS_DEFAULTS_RST  32'hf0ffffff
`define BRS_PERIOD_RST    8'hff
`define BRS_ST_POR        5'h03
`define BRS_ST_WDTRST     5'h01
`define BRS_ST_MCLRSLP    5'h02
`define BRS_PC_VECTOR     13'h0004
`define BRS_PC_RESET      13'h0000

`endif

// [rtl/brs_sequencer.v]
// Brown-out, power-up and start-up reset sequencer with a Wishbone slave.
`timescale 1ns/100ps
`include "brs_defs.vh"

module brs_sequencer #(
  parameter POWERUP_TIMER_TICKS = `BRS_POWERUP_TIMER_US * 1000 / `BRS_TICK_NS,
  parameter FILT_TICKS = `BRS_FILT_US * 1000 / `BRS_TICK_NS
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Asynchronous inputs from pins and detectors
  input  wire        porPulse,
  input  wire        supplyLow,
  input  wire        external_reset_pin_n,
  input  wire        oscClk,
  // Core signals on this clock
  input  wire        cpuSleep,
  input  wire        wdtTimeout,
  input  wire        wakeIrq,
  input  wire        global_irq_enable,
  input  wire [12:0] cpuPc,
  // Sequencer outputs
  output reg         coreReset_n_r,
  output reg         coreRun_r,
  output reg         pcLoad_r,
  output reg  [12:0] pcValue_r,
  output reg  [6:0]  config_r,
  output reg  [31:0] defaults_r,
  output reg  [7:0]  period_r,
  output reg         irq_r
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_POWERUP_TIMER = 3'd1;
  localparam [2:0] ST_OST  = 3'd2;
  localparam [2:0] ST_BOR  = 3'd3;
  localparam [2:0] ST_HOLD = 3'd4;
  localparam [2:0] ST_RUN  = 3'd5;

  localparam integer TICK_CYC = `BRS_TICK_NS * `BRS_CLK_MHZ / 1000;
  localparam integer TICK_M1  = TICK_CYC - 1;
  localparam integer POWERUP_TIMER_M1  = POWERUP_TIMER_TICKS - 1;
  localparam integer FILT_I   = FILT_TICKS;
  localparam integer OST_M1   = `BRS_OST_PERIODS - 1;
  localparam [6:0]  TICK_LIM = TICK_M1[6:0];
  localparam [19:0] POWERUP_TIMER_LIM = POWERUP_TIMER_M1[19:0];
  localparam [19:0] FILT_LIM = FILT_I[19:0];
  localparam [19:0] OST_LIM  = OST_M1[19:0];

  // Low power, plain and fast crystal modes are codes 0 to 2.
  function isCrystal;
    input [2:0] mode;
    begin
      isCrystal = (mode < 3'd3);
    end
  endfunction

  function [7:0] laneMerge;
    input [7:0] oldVal;
    input [7:0] newVal;
    input       en;
    begin
      laneMerge = en ? newVal : oldVal;
    end
  endfunction

  // ****************************************************************
  // Synchronisers and slow tick
  // ****************************************************************
  reg  [3:0]  syncA_r;
  reg  [3:0]  syncB_r;
  reg  [3:0]  syncC_r;
  reg  [3:0]  lvl_r;
  reg         oscPrev_r;
  reg         porPrev_r;
  reg         sleepPrev_r;
  reg  [6:0]  tickCnt_r;
  reg         tick_r;

  wire [3:0]  rawIn = {oscClk, external_reset_pin_n, supplyLow, porPulse};

  // A change counts only once the second and third stages agree.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r   <= 4'h4;
      syncB_r   <= 4'h4;
      syncC_r   <= 4'h4;
      lvl_r     <= 4'h4;
      tickCnt_r <= 7'h00;
      tick_r    <= 1'b0;
    end
    else
    begin
      syncA_r <= rawIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      lvl_r   <= (syncB_r & syncC_r) | (lvl_r & (syncB_r | syncC_r));
      // Stand-in for the internal RC so the power-up timer and filter never depend on oscClk.
      tick_r  <= (tickCnt_r == TICK_LIM);
      if (tickCnt_r == TICK_LIM)
        tickCnt_r <= 7'h00;
      else
        tickCnt_r <= tickCnt_r + 7'h01;
    end
  end

  wire brownout_enable    = config_r[2];
  wire pwrtOn   = ~config_r[3];
  wire xtal     = isCrystal(config_r[6:4]);
  wire porRise  = lvl_r[0] & ~porPrev_r;
  wire lowLvl   = lvl_r[1] & brownout_enable;
  wire pinHigh  = lvl_r[2];
  wire oscRise  = lvl_r[3] & ~oscPrev_r;
  wire sleepRise = cpuSleep & ~sleepPrev_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  reg  [2:0]  st_r;
  reg  [19:0] cnt_r;
  reg  [19:0] filtCnt_r;
  reg         wakeSeq_r;
  reg  [2:0]  stNxt;
  reg  [4:0]  cause;
  reg         wakeNxt;

  wire filtTrip = lowLvl & tick_r & (filtCnt_r == FILT_LIM);

  always @*
  begin
    stNxt   = st_r;
    cause   = 5'h00;
    wakeNxt = wakeSeq_r;
    if (porRise)
    begin
      cause[`BRS_EV_POR] = 1'b1;
      wakeNxt = 1'b0;
      if (pwrtOn)
        stNxt = ST_POWERUP_TIMER;
      else if (xtal)
        stNxt = ST_OST;
      else
        stNxt = ST_HOLD;
    end
    else if (st_r == ST_BOR)
    begin
      if (!lowLvl)
        stNxt = ST_POWERUP_TIMER;
    end
    else if (st_r == ST_POWERUP_TIMER && lowLvl)
      stNxt = ST_BOR;
    else if (filtTrip && st_r != ST_IDLE)
    begin
      cause[`BRS_EV_BOR] = 1'b1;
      wakeNxt = 1'b0;
      stNxt = ST_BOR;
    end
    else
    begin
      case (st_r)
        ST_POWERUP_TIMER:
          if (tick_r && cnt_r == POWERUP_TIMER_LIM)
            stNxt = xtal ? ST_OST : ST_HOLD;
        ST_OST:
          if (oscRise && cnt_r == OST_LIM)
          begin
            stNxt = wakeSeq_r ? ST_RUN : ST_HOLD;
            wakeNxt = 1'b0;
          end
        ST_HOLD:
          if (pinHigh)
            stNxt = ST_RUN;
        ST_RUN:
          if (!pinHigh)
          begin
            cause[`BRS_EV_EXTERNAL_RESET_PIN_N] = 1'b1;
            stNxt = ST_HOLD;
          end
          else if (wdtTimeout && !cpuSleep)
          begin
            cause[`BRS_EV_WDT] = 1'b1;
            stNxt = ST_HOLD;
          end
          else if (cpuSleep && (wdtTimeout || wakeIrq))
          begin
            cause[`BRS_EV_WAKE] = 1'b1;
            if (xtal)
            begin
              stNxt = ST_OST;
              wakeNxt = 1'b1;
            end
          end
        default:
          stNxt = st_r;
      endcase
    end
  end

  wire resetCls = |cause[3:0];
  wire wbTake   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWr     = wbTake & wb_we_i;
  wire rdClr    = wbTake & ~wb_we_i & (wb_adr_i == `BRS_A_IRQSTAT);

  reg  [3:0]  power_control_status_r;
  reg  [4:0]  statusHi_r;
  reg  [4:0]  irqStat_r;
  reg  [4:0]  irqMask_r;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r          <= ST_IDLE;
      cnt_r         <= 20'h00000;
      filtCnt_r     <= 20'h00000;
      wakeSeq_r     <= 1'b0;
      oscPrev_r     <= 1'b0;
      porPrev_r     <= 1'b0;
      sleepPrev_r   <= 1'b0;
      coreReset_n_r <= 1'b0;
      coreRun_r     <= 1'b0;
      pcLoad_r      <= 1'b0;
      pcValue_r     <= `BRS_PC_RESET;
      power_control_status_r        <= 4'h8;
      statusHi_r    <= `BRS_ST_POR;
      defaults_r    <= `BRS_DEFAULTS_RST;
      period_r      <= `BRS_PERIOD_RST;
      irqStat_r     <= 5'h00;
      irq_r         <= 1'b0;
    end
    else
    begin
      st_r        <= stNxt;
      wakeSeq_r   <= wakeNxt;
      oscPrev_r   <= lvl_r[3];
      porPrev_r   <= lvl_r[0];
      sleepPrev_r <= cpuSleep;
      pcLoad_r    <= 1'b0;
      coreRun_r   <= (stNxt == ST_RUN);
      coreReset_n_r <= (stNxt == ST_RUN) || (stNxt == ST_OST && wakeNxt);
      if (stNxt != st_r)
        cnt_r <= 20'h00000;
      else if ((st_r == ST_POWERUP_TIMER && tick_r) || (st_r == ST_OST && oscRise))
        cnt_r <= cnt_r + 20'h00001;
      // The filter restarts on every return above the trip level.
      if (!lowLvl || st_r == ST_BOR || st_r == ST_POWERUP_TIMER || st_r == ST_IDLE)
        filtCnt_r <= 20'h00000;
      else if (tick_r && filtCnt_r != FILT_LIM)
        filtCnt_r <= filtCnt_r + 20'h00001;
      if (sleepRise && st_r == ST_RUN)
        statusHi_r[1:0] <= 2'b10;
      // Software writes come first so a same-cycle cause overrides them.
      if (wbWr && wb_adr_i == `BRS_A_POWER_CONTROL_STATUS && wb_sel_i[0])
      begin
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_BOR]  <= wb_dat_i[0];
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_POR]  <= wb_dat_i[1];
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_OSCF] <= wb_dat_i[3];
      end
      if (wbWr && wb_adr_i == `BRS_A_DEFAULTS)
      begin
        defaults_r[7:0]   <= laneMerge(defaults_r[7:0], wb_dat_i[7:0],
                                       wb_sel_i[0]);
        defaults_r[15:8]  <= laneMerge(defaults_r[15:8], wb_dat_i[15:8],
                                       wb_sel_i[1]);
        defaults_r[23:16] <= laneMerge(defaults_r[23:16], wb_dat_i[23:16],
                                       wb_sel_i[2]);
        defaults_r[31:24] <= laneMerge(defaults_r[31:24], wb_dat_i[31:24],
                                       wb_sel_i[3]);
      end
      if (wbWr && wb_adr_i == `BRS_A_PERIOD && wb_sel_i[0])
        period_r <= wb_dat_i[7:0];
      if (cause[`BRS_EV_POR])
      begin
        statusHi_r <= `BRS_ST_POR;
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_POR] <= 1'b0;
      end
      if (cause[`BRS_EV_BOR])
      begin
        statusHi_r <= `BRS_ST_POR;
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_BOR] <= 1'b0;
      end
      if (cause[`BRS_EV_EXTERNAL_RESET_PIN_N])
      begin
        if (cpuSleep)
          statusHi_r <= `BRS_ST_MCLRSLP;
        else
          statusHi_r[4:2] <= 3'b000;
      end
      if (cause[`BRS_EV_WDT])
        statusHi_r <= `BRS_ST_WDTRST;
      if (resetCls)
      begin
        power_control_status_r[`BRS_POWER_CONTROL_STATUS_OSCF] <= 1'b1;
        defaults_r <= `BRS_DEFAULTS_RST;
        pcValue_r  <= `BRS_PC_RESET;
        pcLoad_r   <= 1'b1;
      end
      if (cause[`BRS_EV_WAKE])
      begin
        pcLoad_r <= 1'b1;
        if (wdtTimeout)
        begin
          statusHi_r[1:0] <= 2'b00;
          pcValue_r <= cpuPc + 13'h0001;
        end
        else
        begin
          statusHi_r[1:0] <= 2'b10;
          pcValue_r <= global_irq_enable ? `BRS_PC_VECTOR
                                         : cpuPc + 13'h0001;
        end
      end
      if (resetCls || cause[`BRS_EV_WAKE])
        period_r <= `BRS_PERIOD_RST;
      irqStat_r <= (rdClr ? 5'h00 : irqStat_r) | cause;
      irq_r     <= |(((rdClr ? 5'h00 : irqStat_r) | cause) & irqMask_r);
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      config_r  <= `BRS_CONFIG_RST;
      irqMask_r <= 5'h00;
    end
    else
    begin
      wb_ack_o <= wbTake;
      if (wbWr && wb_sel_i[0])
      begin
        if (wb_adr_i == `BRS_A_CONFIG)
          config_r <= wb_dat_i[6:0];
        else if (wb_adr_i == `BRS_A_IRQMASK)
          irqMask_r <= wb_dat_i[4:0];
      end
      if (wbTake && !wb_we_i)
      begin
        if (wb_adr_i == `BRS_A_CONFIG)
          wb_dat_o <= {25'h0, config_r};
        else if (wb_adr_i == `BRS_A_POWER_CONTROL_STATUS)
          wb_dat_o <= {28'h0, power_control_status_r[3], 1'b0, power_control_status_r[1:0]};
        else if (wb_adr_i == `BRS_A_STATUS)
          wb_dat_o <= {24'h0, statusHi_r, 3'b000};
        else if (wb_adr_i == `BRS_A_IRQSTAT)
          wb_dat_o <= {27'h0, irqStat_r};
        else if (wb_adr_i == `BRS_A_IRQMASK)
          wb_dat_o <= {27'h0, irqMask_r};
        else if (wb_adr_i == `BRS_A_DEFAULTS)
          wb_dat_o <= defaults_r;
        else if (wb_adr_i == `BRS_A_PERIOD)
          wb_dat_o <= {24'h0, period_r};
        else if (wb_adr_i == `BRS_A_SEQ)
          wb_dat_o <= {29'h0, st_r};
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule // brs_sequencer

// [tb/brs_supply_model.sv]
// Far side model: power-on detector, supply comparator, pin and crystal.
`timescale 1ns/100ps
module brs_supply_model (
  // Detector, pin and oscillator outputs
  output reg porPulse,
  output reg supplyLow,
  output reg external_reset_pin_n,
  output reg oscClk
);
  initial
  begin
    porPulse = 1'b0;
    supplyLow = 1'b0;
    external_reset_pin_n = 1'b1;
    oscClk = 1'b0;
  end

  // A half-step phase offset keeps crystal edges off every core clock edge.
  initial
  begin
    #0.5;
    forever #21 oscClk = ~oscClk;
  end

  // Callers step the detectors just after a core clock edge.
  task automatic drive(input por, input low, input pinN);
    begin
      porPulse <= por;
      supplyLow <= low;
      external_reset_pin_n <= pinN;
    end
  endtask
endmodule // brs_supply_model

// [tb/brs_checker_sva.sv]
// Port checker for the reset sequencer, attached by bind.
`timescale 1ns/100ps
module brs_checker #(
  parameter FILT_TICKS = 2
) (
  // Clock, reset and bus handshake
  input wire        clock,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // Supply, pin and core events
  input wire        supplyLow,
  input wire        external_reset_pin_n,
  input wire        cpuSleep,
  input wire        wdtTimeout,
  input wire        wakeIrq,
  input wire        global_irq_enable,
  input wire [12:0] cpuPc,
  // Sequencer outputs
  input wire        coreReset_n_r,
  input wire        coreRun_r,
  input wire        pcLoad_r,
  input wire [12:0] pcValue_r,
  input wire [6:0]  config_r
);
  // The filter may start one tick late and trips a tick after its count, so allow two ticks and sync slack.
  localparam int LowMax = (FILT_TICKS + 2) * 125 + 8;
  reg [15:0] lowCnt_r;

  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      lowCnt_r <= 16'h0000;
    else if (!(supplyLow && config_r[2]))
      lowCnt_r <= 16'h0000;
    else if (lowCnt_r != 16'hffff)
      lowCnt_r <= lowCnt_r + 16'h0001;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_RUN_OUT_OF_RESET:
    assert property (coreRun_r |-> coreReset_n_r)
    else $error("core runs while held in reset");
  AST_BROWNOUT_TRIPS:
    assert property (lowCnt_r > LowMax |-> !coreRun_r)
    else $error("long supply dip did not stop the core");
  AST_PIN_HOLDS:
    assert property ((!external_reset_pin_n) [*8] |-> !coreRun_r)
    else $error("core runs with reset pin low");
  AST_PIN_RELEASE:
    assert property ($rose(coreRun_r) |-> $past(external_reset_pin_n, 2))
    else $error("core started while pin was low");
  AST_WDT_RESET:
    assert property (coreRun_r && !cpuSleep && wdtTimeout
      |-> ##[1:2] (pcLoad_r && pcValue_r == 13'h0000))
    else $error("watchdog reset did not load address zero");
  AST_WAKE_VECTOR:
    assert property (coreRun_r && cpuSleep && wakeIrq && global_irq_enable
      && !wdtTimeout |-> ##[1:2] (pcLoad_r && pcValue_r == 13'h0004))
    else $error("interrupt wake did not load the vector");
  AST_WAKE_NEXT:
    assert property (coreRun_r && cpuSleep
      && (wdtTimeout || wakeIrq && !global_irq_enable)
      |-> ##[1:2] (pcLoad_r && pcValue_r == cpuPc + 13'h0001))
    else $error("wake did not load the next address");
  AST_WAKE_NO_RESET:
    assert property (coreRun_r && cpuSleep && (wakeIrq || wdtTimeout)
      |=> coreReset_n_r [*4])
    else $error("wake from sleep reset the core");
  AST_PC_PULSE:
    assert property (pcLoad_r |=> !pcLoad_r)
    else $error("address load longer than one cycle");
endmodule // brs_checker

bind brs_sequencer brs_checker #(.FILT_TICKS(FILT_TICKS)) i_chk (
  .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .supplyLow,
  .external_reset_pin_n, .cpuSleep, .wdtTimeout, .wakeIrq,
  .global_irq_enable, .cpuPc, .coreReset_n_r, .coreRun_r, .pcLoad_r,
  .pcValue_r, .config_r);

// [tb/tb_brownout_reset_sequencer.sv]
// Self-checking bench for the brown-out reset sequencer.
`timescale 1ns/100ps
module tb_brownout_reset_sequencer;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
  } brs_row_t;
  reg         clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i, q;
  reg         cpuSleep, wdtTimeout, wakeIrq, global_irq_enable;
  reg  [12:0] cpuPc;
  wire [31:0] wb_dat_o, defaults_r;
  wire        wb_ack_o, porPulse, supplyLow, external_reset_pin_n, oscClk;
  wire        coreReset_n_r, coreRun_r, pcLoad_r, irq_r;
  wire [12:0] pcValue_r;
  wire [6:0]  config_r;
  wire [7:0]  period_r;
  integer     err_total, total_checks;
  brs_row_t   rows [0:15];

  brs_sequencer #(.POWERUP_TIMER_TICKS(4), .FILT_TICKS(2)) i_dut (
    .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .porPulse, .supplyLow,
    .external_reset_pin_n, .oscClk, .cpuSleep, .wdtTimeout, .wakeIrq,
    .global_irq_enable, .cpuPc, .coreReset_n_r, .coreRun_r, .pcLoad_r,
    .pcValue_r, .config_r, .defaults_r, .period_r, .irq_r);
  brs_supply_model i_sup (
    .porPulse, .supplyLow, .external_reset_pin_n, .oscClk);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic wb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 40)
      begin
        @(posedge clock);
        n = n + 1;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk(n < 40, 1);
    end
  endtask

  task automatic rd(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      wb(a, 1'b0, 32'h0);
      chk(q & m, e);
    end
  endtask

  task automatic waitRun(input v, input integer lim);
    integer n;
    begin
      n = 0;
      while (coreRun_r !== v && n < lim)
      begin
        @(posedge clock);
        n = n + 1;
      end
      chk(coreRun_r, v);
    end
  endtask

  task automatic sup(input p, input l, input m);
    begin
      @(posedge clock);
      i_sup.drive(p, l, m);
    end
  endtask

  task automatic por(input m);
    begin
      sup(1'b1, 1'b0, m);
      repeat (10) @(posedge clock);
      sup(1'b0, 1'b0, m);
    end
  endtask

  task automatic dutReset;
    begin
      rst_n <= 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
    end
  endtask

  // Sleep level, wake request, watchdog and interrupt enable per event.
  task automatic wake(input s, wk, wd, g, input [31:0] st);
    begin
      @(posedge clock);
      cpuSleep <= s;
      global_irq_enable <= g;
      repeat (8) @(posedge clock);
      wakeIrq <= wk;
      wdtTimeout <= wd;
      @(posedge clock);
      wakeIrq <= 1'b0;
      wdtTimeout <= 1'b0;
      repeat (4) @(posedge clock);
      cpuSleep <= 1'b0;
      repeat (30) @(posedge clock);
      rd(8'h08, 32'hf8, st);
    end
  endtask

  task automatic tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // The planned sequence needs about 22000 cycles; allow twice that.
  initial
  begin
    #360000;
    err_total = err_total + 1;
    tally_and_finish;
  end

  initial
  begin
    err_total = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
    wb_sel_i = 4'hf;
    {cpuSleep, wdtTimeout, wakeIrq, global_irq_enable} = 4'h0;
    cpuPc = 13'h0123;
    rows = '{'{8'h00, 1'b0, 32'h14}, '{8'h14, 1'b0, 32'hf0ffffff},
      '{8'h18, 1'b0, 32'hff}, '{8'h00, 1'b1, 32'h15}, '{8'h00, 1'b0, 32'h15},
      '{8'h00, 1'b1, 32'h16}, '{8'h00, 1'b0, 32'h16}, '{8'h00, 1'b1, 32'h17},
      '{8'h00, 1'b0, 32'h17}, '{8'h00, 1'b1, 32'h14}, '{8'h14, 1'b1, 32'h0},
      '{8'h14, 1'b0, 32'h0}, '{8'h18, 1'b1, 32'h5a}, '{8'h18, 1'b0, 32'h5a},
      '{8'h20, 1'b1, 32'hff}, '{8'h20, 1'b0, 32'h0}};
    dutReset;
    foreach (rows[i])
      if (rows[i].w)
        wb(rows[i].a, 1'b1, rows[i].d);
      else
        rd(rows[i].a, 32'hffffffff, rows[i].d);
    $display("test registers done");
    por(1'b1);
    repeat (5400) @(posedge clock);
    chk(coreRun_r, 1'b0);
    waitRun(1'b1, 1200);
    rd(8'h04, 32'h0a, 32'h08);
    rd(8'h08, 32'hf8, 32'h18);
    chk(defaults_r, 32'hf0ffffff);
    chk(period_r, 8'hff);
    wb(8'h10, 1'b1, 32'h0);
    chk(irq_r, 1'b0);
    wb(8'h10, 1'b1, 32'h1f);
    repeat (2) @(posedge clock);
    chk(irq_r, 1'b1);
    rd(8'h0c, 32'h1f, 32'h02);
    repeat (2) @(posedge clock);
    chk(irq_r, 1'b0);
    wb(8'h04, 1'b1, 32'h0b);
    $display("test power-on done");
    wb(8'h00, 1'b1, 32'h38);
    sup(1'b0, 1'b1, 1'b1);
    repeat (1000) @(posedge clock);
    chk(coreRun_r, 1'b1);
    sup(1'b0, 1'b0, 1'b1);
    wb(8'h00, 1'b1, 32'h3c);
    sup(1'b0, 1'b1, 1'b1);
    repeat (150) @(posedge clock);
    sup(1'b0, 1'b0, 1'b1);
    repeat (10) @(posedge clock);
    chk(coreRun_r, 1'b1);
    sup(1'b0, 1'b1, 1'b1);
    waitRun(1'b0, 600);
    repeat (100) @(posedge clock);
    sup(1'b0, 1'b0, 1'b1);
    repeat (300) @(posedge clock);
    sup(1'b0, 1'b1, 1'b1);
    repeat (20) @(posedge clock);
    sup(1'b0, 1'b0, 1'b1);
    repeat (360) @(posedge clock);
    chk(coreRun_r, 1'b0);
    waitRun(1'b1, 300);
    rd(8'h04, 32'h03, 32'h02);
    rd(8'h08, 32'hf8, 32'h18);
    rd(8'h0c, 32'h1f, 32'h01);
    wb(8'h04, 1'b1, 32'h0b);
    $display("test brown-out done");
    sup(1'b0, 1'b0, 1'b0);
    waitRun(1'b0, 12);
    sup(1'b0, 1'b0, 1'b1);
    waitRun(1'b1, 12);
    rd(8'h04, 32'h03, 32'h03);
    rd(8'h0c, 32'h1f, 32'h04);
    wake(1'b0, 1'b0, 1'b1, 1'b1, 32'h08);
    wake(1'b1, 1'b1, 1'b0, 1'b1, 32'h10);
    wake(1'b1, 1'b1, 1'b0, 1'b0, 32'h10);
    wake(1'b1, 1'b0, 1'b1, 1'b1, 32'h00);
    rd(8'h04, 32'h03, 32'h03);
    $display("test pin and wake done");
    dutReset;
    wb(8'h00, 1'b1, 32'h3c);
    por(1'b1);
    waitRun(1'b1, 20);
    dutReset;
    por(1'b0);
    repeat (7000) @(posedge clock);
    chk(coreRun_r, 1'b0);
    sup(1'b0, 1'b0, 1'b1);
    waitRun(1'b1, 12);
    $display("test second power-on done");
    wake(1'b1, 1'b1, 1'b0, 1'b1, 32'h10);
    chk(coreRun_r, 1'b0);
    chk(coreReset_n_r, 1'b1);
    waitRun(1'b1, 6000);
    $display("test crystal wake done");
    tally_and_finish;
  end
endmodule // tb_brownout_reset_sequencer
